// [tb_top.sv]
// self-checking bench for the crosspoint command decoder
`timescale 1ns/1ps
module tb_top;
  logic clk_sys_i = 1'h0;
  logic nrst_i = 1'h1;
  logic sclk, serial_word_in, latch, clamp, oper, goe, bc;
  logic [15:0] en = 16'hA5C3;
  logic [63:0] map = 64'h0123456789ABCDEF;
  logic [63:0] route;
  logic [15:0] drive;
  logic [3:0] idx;
  int failures = 0;
  int n_compared = 0;
  // word to send, then expected {broadcast, index, clamp, operational, global enable}
  logic [23:0] rows [10] = '{24'hE30107, 24'h7A01EF, 24'h9E01EF, 24'h7A006F, 24'h7E01FF,
    24'h600187, 24'hE10082, 24'h600002, 24'hE20105, 24'hE00000};
  // free-running system clock
  always #5 clk_sys_i = ~clk_sys_i;
  xbc_decode u_dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .shift_clk_i(sclk),
    .serial_word_in_i(serial_word_in), .word_commit_strobe_i(latch), .chan_enable_i(en),
    .map_sel_i(map), .route_sel_o(route), .out_drive_o(drive), .clamp_en_o(clamp),
    .operational_o(oper), .global_oe_o(goe), .bcast_active_o(bc),
    .broadcast_input_index_o(idx));
  xbc_host u_host (.sclk_o(sclk), .sdi_o(serial_word_in), .latch_o(latch));
  // one comparison, counted
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // state outputs plus the routing and drive they imply
  task automatic check_state(input logic [7:0] e);
    chk({bc, idx, clamp, oper, goe}, e);
    chk(route, e[7] ? {16{e[6:3]}} : map);
    chk(drive, en & {16{e[1] & e[0]}});
  endtask
  task automatic close_out;
    if (failures == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // hang guard
  initial begin
    #200000 failures++;
    close_out;
  end
  // reset, table of words, then a reset in mid-run
  initial begin
    #1 nrst_i = 1'h0;
    repeat (8) @(posedge clk_sys_i);
    #1 nrst_i = 1'h1;
    repeat (3) @(posedge clk_sys_i);
    #1 check_state(8'h00);
    // broadcast words keep B8..B1 zero, clamp kept off at the end
    foreach (rows[i]) begin
      map = {map[59:0], map[63:60]}; // mapping moves, also under broadcast
      en = {en[14:0], en[15]};
      u_host.send(rows[i][23:8]);
      repeat (8) @(posedge clk_sys_i);
      #1 check_state(rows[i][7:0]);
    end
    u_host.send(16'h7A01);
    u_host.send(16'hE301);
    @(posedge clk_sys_i);
    #1 check_state(8'hEF);
    nrst_i = 1'h0;
    @(posedge clk_sys_i);
    #1 chk(route, 64'h0);
    chk(drive, 64'h0);
    chk({bc, idx, clamp, oper, goe}, 64'h0);
    nrst_i = 1'h1;
    repeat (3) @(posedge clk_sys_i);
    #1 check_state(8'h00);
    close_out;
  end
endmodule

// [xbc_decode.sv]
// serial command decoder for the broadcast and global control words
`timescale 1ns/1ps
module xbc_decode #(
  parameter int N_CH = 16
) (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic shift_clk_i,
  input wire logic serial_word_in_i,
  input wire logic word_commit_strobe_i,
  input wire logic [N_CH-1:0] chan_enable_i,
  input wire logic [N_CH*4-1:0] map_sel_i,
  output logic [N_CH*4-1:0] route_sel_o,
  output logic [N_CH-1:0] out_drive_o,
  output logic clamp_en_o,
  output logic operational_o,
  output logic global_oe_o,
  output logic bcast_active_o,
  output logic [3:0] broadcast_input_index_o
);
  logic [2:0] sclk_sync_r;
  logic [2:0] sdi_sync_r;
  logic [2:0] latch_sync_r;
  logic [xbc_pkg::WORD_W-1:0] shift_r;
  logic [2:0] cmd;
  logic sclk_rise;
  logic latch_rise;

  // two-flop synchronisers; the third stage serves edge detection and gives the data bit that is shifted in
  // the shift clock and strobe are pins from the host's domain, so a bit
  // is taken about three system clocks after its shift clock rise
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sclk_sync_r <= 3'h0;
      sdi_sync_r <= 3'h0;
      latch_sync_r <= 3'h0;
    end else begin
      sclk_sync_r <= {sclk_sync_r[1:0], shift_clk_i};
      sdi_sync_r <= {sdi_sync_r[1:0], serial_word_in_i};
      latch_sync_r <= {latch_sync_r[1:0], word_commit_strobe_i};
    end
  end

  // edges seen on synchronised copies only
  assign sclk_rise = sclk_sync_r[1] & ~sclk_sync_r[2];
  assign latch_rise = latch_sync_r[1] & ~latch_sync_r[2];
  assign cmd = shift_r[xbc_pkg::CMD_HI:xbc_pkg::CMD_LO];

  // shift in lsb first; the last bit shifted lands in the msb
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      shift_r <= 16'h0000;
    end else if (sclk_rise) begin
      shift_r <= {sdi_sync_r[2], shift_r[xbc_pkg::WORD_W-1:1]};
    end
  end

  // broadcast state, kept apart from the per-output mapping
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bcast_active_o <= xbc_pkg::RST_BCAST;
      broadcast_input_index_o <= xbc_pkg::RST_SEL;
    end else if (latch_rise && cmd == xbc_pkg::CMD_BCAST) begin
      bcast_active_o <= shift_r[xbc_pkg::BCAST_EN_BIT];
      broadcast_input_index_o <= shift_r[xbc_pkg::SEL_HI:xbc_pkg::SEL_LO];
    end
  end

  // global control word
  // standby bit sits at B8, 1 meaning operational; clamp at B9, enable at B0
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      clamp_en_o <= xbc_pkg::RST_CLAMP;
      operational_o <= xbc_pkg::RST_OPER;
      global_oe_o <= xbc_pkg::RST_GOE;
    end else if (latch_rise && cmd == xbc_pkg::CMD_CTRL) begin
      clamp_en_o <= shift_r[xbc_pkg::CLAMP_BIT];
      operational_o <= shift_r[xbc_pkg::STANDBY_BIT];
      global_oe_o <= shift_r[xbc_pkg::GOE_BIT];
    end
  end

  // per-output route and drive; mapping input is never overwritten
  // so the current map_sel_i routing comes back one cycle after broadcast ends
  genvar g;
  generate
    for (g = 0; g < N_CH; g++) begin : g_out
      always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
          route_sel_o[g*4 +: 4] <= xbc_pkg::RST_SEL;
          out_drive_o[g] <= 1'h0;
        end else begin
          route_sel_o[g*4 +: 4] <= bcast_active_o ? broadcast_input_index_o
                                                  : map_sel_i[g*4 +: 4];
          out_drive_o[g] <= chan_enable_i[g] & global_oe_o & operational_o;
        end
      end
    end
  endgenerate

  // checks on the decoded state; all but the reset check are off in reset
  // broadcast enable follows bit 0 of a committed broadcast word
  property p_bcast_commit;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      latch_rise && cmd == xbc_pkg::CMD_BCAST |=> bcast_active_o == $past(shift_r[0]);
  endproperty
  a_bcast_commit: assert property (p_bcast_commit) else $error("broadcast enable not taken");
  // broadcast index follows the 4-bit field of a committed broadcast word
  property p_bcast_sel;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      latch_rise && cmd == xbc_pkg::CMD_BCAST |=> broadcast_input_index_o == $past(shift_r[12:9]);
  endproperty
  a_bcast_sel: assert property (p_bcast_sel) else $error("broadcast index wrong");
  // every output carries the broadcast input one cycle after broadcast is on
  property p_route_bcast;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      bcast_active_o |=> route_sel_o == {N_CH{$past(broadcast_input_index_o)}};
  endproperty
  a_route_bcast: assert property (p_route_bcast) else $error("broadcast route wrong");
  // with broadcast off the kept per-output mapping comes back
  property p_route_restore;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      !bcast_active_o |=> route_sel_o == $past(map_sel_i);
  endproperty
  a_route_restore: assert property (p_route_restore) else $error("mapping not restored");
  // control word fields land in clamp, mode and global enable
  property p_ctrl_commit;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      latch_rise && cmd == xbc_pkg::CMD_CTRL |=>
        {clamp_en_o, operational_o, global_oe_o} == $past({shift_r[9], shift_r[8], shift_r[0]});
  endproperty
  a_ctrl_commit: assert property (p_ctrl_commit) else $error("control word not taken");
  // codes other than broadcast and control leave clamp, mode, global enable and broadcast enable alone
  property p_unknown;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      latch_rise && cmd != xbc_pkg::CMD_CTRL && cmd != xbc_pkg::CMD_BCAST |=>
        $stable({clamp_en_o, operational_o, global_oe_o, bcast_active_o});
  endproperty
  a_unknown: assert property (p_unknown) else $error("unknown command changed state");
  // global enable low for two cycles keeps every output off
  property p_goe_off;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      !global_oe_o ##1 !global_oe_o |-> out_drive_o == '0;
  endproperty
  a_goe_off: assert property (p_goe_off) else $error("output driven without global enable");
  // each output enable is its own enable ANDed with the global ones
  property p_and;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      1 |=> out_drive_o == ($past(chan_enable_i) & {N_CH{$past(global_oe_o & operational_o)}});
  endproperty
  a_and: assert property (p_and) else $error("output enable not gated");
  // newest serial bit lands in the msb
  property p_shift;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      sclk_rise |=> shift_r[15] == $past(sdi_sync_r[2]);
  endproperty
  a_shift: assert property (p_shift) else $error("shift bit lost");
  // reset alone gives standby with every output off
  property p_reset_off;
    @(posedge clk_sys_i)
      !nrst_i |-> out_drive_o == '0 && !operational_o && !global_oe_o && !clamp_en_o
        && !bcast_active_o;
  endproperty
  a_reset_off: assert property (p_reset_off)
    else $error("reset did not give standby");
  // decoded state changes only at a commit strobe edge
  property p_state_hold;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      !latch_rise |=> $stable({bcast_active_o, broadcast_input_index_o, clamp_en_o,
        operational_o, global_oe_o});
  endproperty
  a_state_hold: assert property (p_state_hold)
    else $error("state changed without strobe");
  // the shift register moves only on a shift clock edge
  property p_shift_hold;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      !sclk_rise |=> $stable(shift_r);
  endproperty
  a_shift_hold: assert property (p_shift_hold)
    else $error("shift register moved without clock");
  // standby keeps every output off whatever the enables say
  property p_standby_off;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      !operational_o ##1 !operational_o |-> out_drive_o == '0;
  endproperty
  a_standby_off: assert property (p_standby_off)
    else $error("output driven in standby");
  // a control word leaves the broadcast state alone
  property p_ctrl_keeps_bcast;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      latch_rise && cmd == xbc_pkg::CMD_CTRL |=>
        $stable({bcast_active_o, broadcast_input_index_o});
  endproperty
  a_ctrl_keeps_bcast: assert property (p_ctrl_keeps_bcast)
    else $error("control word changed broadcast");
  // a broadcast word leaves the control state alone
  property p_bcast_keeps_ctrl;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      latch_rise && cmd == xbc_pkg::CMD_BCAST |=>
        $stable({clamp_en_o, operational_o, global_oe_o});
  endproperty
  a_bcast_keeps_ctrl: assert property (p_bcast_keeps_ctrl)
    else $error("broadcast word changed control");
  // main scenarios reached
  c_bcast_on: cover property (@(posedge clk_sys_i) $rose(bcast_active_o));
  c_bcast_off: cover property (@(posedge clk_sys_i) $fell(bcast_active_o));
  c_enable: cover property (@(posedge clk_sys_i) $rose(global_oe_o & operational_o));
  c_ignored: cover property (@(posedge clk_sys_i)
    latch_rise && cmd != xbc_pkg::CMD_CTRL && cmd != xbc_pkg::CMD_BCAST);
  c_bcast_move: cover property (@(posedge clk_sys_i)
    bcast_active_o && $changed(broadcast_input_index_o));
endmodule

// [xbc_host.sv]
// host model that shifts command words into the decoder
`timescale 1ns/1ps
module xbc_host (
  output logic sclk_o,
  output logic sdi_o,
  output logic latch_o
);
  // lines start idle
  initial begin
    sclk_o = 1'h0;
    sdi_o = 1'h0;
    latch_o = 1'h0;
  end
  // lsb first, bit set while clock low, clock still between words
  task automatic send(input logic [15:0] w);
    for (int i = 0; i < 16; i++) begin
      sdi_o = w[i];
      #80 sclk_o = 1'h1;
      #80 sclk_o = 1'h0;
    end
    sdi_o = ~w[15]; // released line never shows the last bit
    #40 latch_o = 1'h1;
    #80 latch_o = 1'h0;
  endtask
endmodule

// [xbc_pkg.sv]
// package of command codes, field positions and reset values for the crosspoint command decoder
package xbc_pkg;
  localparam int WORD_W = 16;
  localparam int CMD_HI = 15;
  localparam int CMD_LO = 13;
  localparam logic [2:0] CMD_MAP = 3'h0;
  localparam logic [2:0] CMD_BCAST = 3'h3;
  localparam logic [2:0] CMD_CTRL = 3'h7;
  localparam int SEL_HI = 12;
  localparam int SEL_LO = 9;
  localparam int BCAST_EN_BIT = 0;
  localparam int CLAMP_BIT = 9;
  localparam int STANDBY_BIT = 8;
  localparam int GOE_BIT = 0;
  localparam logic RST_CLAMP = 1'h0;
  localparam logic RST_OPER = 1'h0;
  localparam logic RST_GOE = 1'h0;
  localparam logic RST_BCAST = 1'h0;
  localparam logic [3:0] RST_SEL = 4'h0;
endpackage
